// ---- hw/ptc_pkg.sv ----
package ptc_pkg;

    // timing units of the three timer families
    localparam int FINE_MS = 1; // fine unit in ms
    localparam int ALT_MS = 10; // medium unit in ms
    localparam int COARSE_MS = 100; // coarse unit in ms
    localparam int CLK_KHZ = 125000; // core clock rate in kHz
    localparam int FINE_CYC = FINE_MS * CLK_KHZ; // cycles per fine tick
    localparam logic [3:0] DECADE = 4'h9; // last count of a /10 stage

    // instance counts and ranges
    localparam int NUM_TMR = 512; // timer instances
    localparam int NUM_CNT = 512; // counter instances
    localparam int NUM_OUT = 256; // output points
    localparam logic [8:0] FB_FIRST = 9'h19C; // first fb/interrupt timer
    localparam logic [15:0] CV_MAX = 16'h7FFF; // largest current value
    localparam logic [15:0] CV_ZERO = 16'h0000; // cleared current value

    // register byte offsets
    localparam logic [7:0] OFS_SEL = 8'h00; // instance select
    localparam logic [7:0] OFS_TMR_CV = 8'h04; // timer current value
    localparam logic [7:0] OFS_TMR_ST = 8'h08; // timer status
    localparam logic [7:0] OFS_CNT_CV = 8'h0C; // counter current value
    localparam logic [7:0] OFS_CNT_SV = 8'h10; // counter set value
    localparam logic [7:0] OFS_CNT_ST = 8'h14; // counter status / latch
    localparam logic [7:0] OFS_SCANS = 8'h18; // completed scans

    // field positions
    localparam int ST_OUT_BIT = 0; // contact bit
    localparam int ST_COIL_BIT = 1; // timer coil bit
    localparam int ST_ACC_BIT = 2; // accumulate bit
    localparam int CST_LATCH_BIT = 1; // counter latching bit
    localparam logic [31:0] RST_WORD = 32'h0000_0000; // reset value

    // instruction codes from the execution engine
    typedef enum logic [3:0] {
        OP_NONE,
        OP_TIMER_INSTR,
        OP_ALT_TIMER_INSTR,
        OP_FINE_TIMER_INSTR,
        OP_TMR_RST,
        OP_CNT,
        OP_CNT_RST,
        OP_OUT,
        OP_IMMEDIATE_OUTPUT_POINT
    } ptc_op_e;

    typedef enum logic [1:0] {
        UNIT_COARSE,
        UNIT_ALT,
        UNIT_FINE
    } ptc_unit_e;

    // one executed instruction
    typedef struct packed {
        logic valid; // instruction present this cycle
        ptc_op_e op; // what executes
        logic [8:0] idx; // timer, counter or output index
        logic cond; // enabling condition or count input
        logic accum_timer_prefix; // accumulative timer form
        logic [15:0] setv; // set value from constant or data register
    } ptc_instr_s;

endpackage

// ---- hw/ptc_timer_counter.sv ----
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - coarse timer advances every 100 ms
// - medium timer advances every 10 ms
// - fine timer advances every 1 ms
// - instruction sets coil; contact when value reaches set
// - general timer clears on false condition or power
// - accumulative timer holds value, resumes from it
// - 512 accumulative timers share timer indices
// - any false condition in scan turns timer off
// - first matching instruction supplies set value
// - output drop while enabled restarts timer
// - upper timers advance at instruction or scan end
// - 512 counters, set value 0 to 32767
// - counter increments on each rising count input
// - counter stops at set value until reset
// - contact on when value equals set value
// - set values 0 and 1 behave alike
// - reset clears value and contact
// - contact turns on only after scan completes; reset, and power loss of a general counter, clear it at once
// - value above set loads set on next edge
// - increment from 32767 gives zero
// - power loss clears general, keeps latching counters
// - regenerated outputs at scan end, direct at once
module ptc_timer_counter
    import ptc_pkg::*;
#(
    parameter int FINE_CYCLES = FINE_CYC // cycles per fine tick
) (
    input wire logic core_clk, // core clock
    input wire logic nrst, // async reset, active low
    input wire logic ce, // clock enable, freezes all state
    input wire ptc_instr_s instr, // instruction from the engine
    input wire logic scan_end, // end-of-scan instruction strobe
    input wire logic pwr_lost, // power loss event strobe
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    output logic [NUM_OUT-1:0] phys_out // physical output pins
);

    // saturating add of pending ticks to a timer value
    function automatic logic [15:0] sat_add(input logic [15:0] v,
                                           input logic [7:0] n);
        logic [16:0] s;
        s = {1'b0, v} + {9'h000, n};
        sat_add = (s > {1'b0, CV_MAX}) ? CV_MAX : s[15:0];
    endfunction

    // counter set value with 0 treated as 1
    function automatic logic [15:0] eff_sv(input logic [15:0] v);
        // only the low 15 bits count, matching the stored set value
        eff_sv = (v[14:0] == 15'h0000) ? 16'h0001 : {1'b0, v[14:0]};
    endfunction

    // 16-bit counter step, wrapping from the top value to zero
    function automatic logic [15:0] cnt_inc(input logic [15:0] v);
        cnt_inc = (v == CV_MAX) ? CV_ZERO : v + 16'h0001;
    endfunction

    // tick generation state
    logic [16:0] fine_div_r; // fine tick divider
    logic [3:0] alt_div_r; // fine ticks toward a medium tick
    logic [3:0] coarse_div_r; // medium ticks toward a coarse tick
    logic tick_fine, tick_alt, tick_coarse; // one-cycle tick pulses

    // timer storage
    logic [15:0] tmr_cv_r [NUM_TMR]; // current values
    logic [15:0] tmr_sv_r [NUM_TMR]; // set values in use
    logic [1:0] tmr_unit_r [NUM_TMR]; // timing unit per timer
    logic [7:0] tmr_pend_r [NUM_TMR]; // ticks waiting for fb timers
    logic [NUM_TMR-1:0] tmr_coil_r; // coil state
    logic [NUM_TMR-1:0] tmr_out_r; // contact state
    logic [NUM_TMR-1:0] tmr_acc_r; // accumulative form
    logic [NUM_TMR-1:0] tmr_blk_r; // some condition false this scan
    logic [NUM_TMR-1:0] tmr_lock_r; // set value taken this scan

    // counter storage
    logic [15:0] cnt_cv_r [NUM_CNT]; // current values
    logic [15:0] cnt_sv_r [NUM_CNT]; // set values
    logic [NUM_CNT-1:0] cnt_prev_r; // last count input level
    logic [NUM_CNT-1:0] cnt_hit_r; // value reached set value
    logic [NUM_CNT-1:0] cnt_ct_r; // contact seen by the program
    logic [NUM_CNT-1:0] cnt_latch_r; // latching counter

    // output image and bus state
    logic [NUM_OUT-1:0] out_img_r; // output states built by the scan
    logic [8:0] sel_r; // instance chosen by software
    logic [31:0] scans_r; // completed scans
    logic [31:0] rd_nxt; // read mux
    logic hit_ok; // address maps to a register
    logic bus_wr; // write takes effect this edge
    logic is_tmr, is_cnt, is_out; // instruction class decode
    logic [8:0] k; // instruction index
    logic [7:0] ko; // output point index

    assign k = instr.idx;
    assign ko = instr.idx[7:0];
    assign bus_wr = psel & penable & pready & pwrite;

    // instruction class decode
    always_comb begin
        is_tmr = 1'b0;
        is_cnt = 1'b0;
        is_out = 1'b0;
        if (instr.valid) begin
            unique case (instr.op)
                OP_TIMER_INSTR, OP_ALT_TIMER_INSTR, OP_FINE_TIMER_INSTR,
                OP_TMR_RST: is_tmr = 1'b1;
                OP_CNT, OP_CNT_RST: is_cnt = 1'b1;
                OP_OUT, OP_IMMEDIATE_OUTPUT_POINT: is_out = 1'b1;
                default: is_out = 1'b0; // unused codes do nothing
            endcase
        end
    end

    // decade tick chain; ticks are pulses only while ce is high
    assign tick_fine = ce && (fine_div_r == 17'(FINE_CYCLES - 1));
    assign tick_alt = tick_fine && (alt_div_r == DECADE);
    assign tick_coarse = tick_alt && (coarse_div_r == DECADE);

    // tick dividers: one free-running base, two /10 stages
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fine_div_r <= '0;
            alt_div_r <= '0;
            coarse_div_r <= '0;
        end else if (ce) begin
            fine_div_r <= tick_fine ? '0 : fine_div_r + 17'h0_0001;
            if (tick_fine) begin
                alt_div_r <= (alt_div_r == DECADE) ? '0 : alt_div_r + 4'h1;
            end
            if (tick_alt) begin
                coarse_div_r <= (coarse_div_r == DECADE) ? '0 :
                                coarse_div_r + 4'h1;
            end
        end
    end

    // timers: ticking, contact compare, scan end, then the instruction
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NUM_TMR; i++) begin
                tmr_cv_r[i] <= CV_ZERO;
                tmr_sv_r[i] <= CV_ZERO;
                tmr_unit_r[i] <= UNIT_COARSE;
                tmr_pend_r[i] <= '0;
            end
            tmr_coil_r <= '0;
            tmr_out_r <= '0;
            tmr_acc_r <= '0;
            tmr_blk_r <= '0;
            tmr_lock_r <= '0;
        end else if (ce) begin
            for (int i = 0; i < NUM_TMR; i++) begin
                // each running timer advances on its own unit's tick
                if (tmr_coil_r[i] &&
                    ((tmr_unit_r[i] == UNIT_COARSE && tick_coarse) ||
                     (tmr_unit_r[i] == UNIT_ALT && tick_alt) ||
                     (tmr_unit_r[i] == UNIT_FINE && tick_fine))) begin
                    if (9'(i) >= FB_FIRST) begin
                        // fb timers only bank ticks until executed or scan end
                        if (tmr_pend_r[i] != 8'hFF) begin
                            tmr_pend_r[i] <= tmr_pend_r[i] + 8'h01;
                        end
                    end else begin
                        tmr_cv_r[i] <= sat_add(tmr_cv_r[i], 8'h01);
                    end
                end
                // contact follows value against set value
                tmr_out_r[i] <= tmr_coil_r[i] &&
                                (tmr_cv_r[i] >= tmr_sv_r[i]);
                if (tmr_out_r[i] && tmr_coil_r[i] &&
                    tmr_cv_r[i] < tmr_sv_r[i]) begin
                    tmr_cv_r[i] <= CV_ZERO;
                end
                // end of scan: fb timers catch up, per-scan flags clear
                if (scan_end) begin
                    if (9'(i) >= FB_FIRST) begin
                        tmr_cv_r[i] <= sat_add(tmr_cv_r[i],
                                               tmr_pend_r[i]);
                        tmr_pend_r[i] <= '0;
                    end
                    tmr_blk_r[i] <= 1'b0;
                    tmr_lock_r[i] <= 1'b0;
                end
                // power loss: general timers lose their value
                if (pwr_lost) begin
                    tmr_coil_r[i] <= 1'b0;
                    tmr_out_r[i] <= 1'b0;
                    if (!tmr_acc_r[i]) begin
                        tmr_cv_r[i] <= CV_ZERO;
                    end
                end
            end
            // software write of a timer value
            if (bus_wr && paddr == OFS_TMR_CV) begin
                tmr_cv_r[sel_r] <= pwdata[15:0];
            end
            // executed timer instruction wins over the above
            if (is_tmr && instr.op == OP_TMR_RST) begin
                tmr_cv_r[k] <= CV_ZERO;
                tmr_pend_r[k] <= '0;
                tmr_coil_r[k] <= 1'b0;
                tmr_out_r[k] <= 1'b0;
            end else if (is_tmr) begin
                // accumulative form is chosen per instruction
                tmr_acc_r[k] <= instr.accum_timer_prefix;
                if (!tmr_lock_r[k]) begin
                    tmr_lock_r[k] <= 1'b1;
                    tmr_sv_r[k] <= instr.setv;
                    tmr_unit_r[k] <= (instr.op == OP_FINE_TIMER_INSTR) ?
                                     UNIT_FINE :
                                     (instr.op == OP_ALT_TIMER_INSTR) ?
                                     UNIT_ALT : UNIT_COARSE;
                end
                if (!instr.cond) begin
                    tmr_blk_r[k] <= 1'b1;
                    tmr_coil_r[k] <= 1'b0;
                    tmr_out_r[k] <= 1'b0;
                    if (!instr.accum_timer_prefix) begin
                        tmr_cv_r[k] <= CV_ZERO;
                        tmr_pend_r[k] <= '0;
                    end else begin
                        // hold beats a tick landing on this same edge
                        tmr_cv_r[k] <= tmr_cv_r[k];
                    end
                end else if (!tmr_blk_r[k]) begin
                    tmr_coil_r[k] <= 1'b1;
                    if (k >= FB_FIRST) begin
                        tmr_cv_r[k] <= sat_add(tmr_cv_r[k],
                                               tmr_pend_r[k]);
                        tmr_pend_r[k] <= '0;
                    end
                end
            end
        end
    end

    // counters: contact publish at scan end, then bus, then instruction
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NUM_CNT; i++) begin
                cnt_cv_r[i] <= CV_ZERO;
                cnt_sv_r[i] <= CV_ZERO;
            end
            cnt_prev_r <= '0;
            cnt_hit_r <= '0;
            cnt_ct_r <= '0;
            cnt_latch_r <= '0;
        end else if (ce) begin
            if (scan_end) begin
                cnt_ct_r <= cnt_hit_r;
            end
            for (int i = 0; i < NUM_CNT; i++) begin
                // latching counters ride through power loss
                if (pwr_lost && !cnt_latch_r[i]) begin
                    cnt_cv_r[i] <= CV_ZERO;
                    cnt_hit_r[i] <= 1'b0;
                    cnt_ct_r[i] <= 1'b0;
                end
            end
            // software access to the selected counter
            if (bus_wr && paddr == OFS_CNT_CV) begin
                cnt_cv_r[sel_r] <= pwdata[15:0];
            end
            if (bus_wr && paddr == OFS_CNT_SV) begin
                cnt_sv_r[sel_r] <= {1'b0, pwdata[14:0]};
            end
            if (bus_wr && paddr == OFS_CNT_ST) begin
                cnt_latch_r[sel_r] <= pwdata[CST_LATCH_BIT];
            end
            // count and reset instructions
            if (is_cnt && instr.op == OP_CNT_RST) begin
                cnt_cv_r[k] <= CV_ZERO;
                cnt_hit_r[k] <= 1'b0;
                cnt_ct_r[k] <= 1'b0;
            end else if (is_cnt) begin
                cnt_prev_r[k] <= instr.cond;
                cnt_sv_r[k] <= {1'b0, instr.setv[14:0]};
                if (instr.cond && !cnt_prev_r[k]) begin
                    if (cnt_cv_r[k] > eff_sv(instr.setv)) begin
                        cnt_cv_r[k] <= eff_sv(instr.setv);
                        cnt_hit_r[k] <= 1'b1;
                    end else if (cnt_cv_r[k] == eff_sv(instr.setv)) begin
                        cnt_hit_r[k] <= 1'b1;
                    end else begin
                        cnt_cv_r[k] <= cnt_inc(cnt_cv_r[k]);
                        cnt_hit_r[k] <= (cnt_inc(cnt_cv_r[k]) ==
                                         eff_sv(instr.setv));
                    end
                end
            end
        end
    end

    // output image and physical pins
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            out_img_r <= '0;
            phys_out <= '0;
        end else if (ce) begin
            if (scan_end) begin
                phys_out <= out_img_r;
            end
            if (is_out) begin
                out_img_r[ko] <= instr.cond;
                if (instr.op == OP_IMMEDIATE_OUTPUT_POINT) begin
                    phys_out[ko] <= instr.cond;
                end
            end
        end
    end

    // scan counter for software
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            scans_r <= RST_WORD;
        end else if (ce && scan_end) begin
            scans_r <= scans_r + 32'h0000_0001;
        end
    end

    // read mux over the selected instance
    always_comb begin
        rd_nxt = RST_WORD;
        hit_ok = 1'b1;
        unique case (paddr)
            OFS_SEL: rd_nxt = {23'h00_0000, sel_r};
            OFS_TMR_CV: rd_nxt = {16'h0000, tmr_cv_r[sel_r]};
            OFS_TMR_ST: begin
                rd_nxt[ST_OUT_BIT] = tmr_out_r[sel_r];
                rd_nxt[ST_COIL_BIT] = tmr_coil_r[sel_r];
                rd_nxt[ST_ACC_BIT] = tmr_acc_r[sel_r];
            end
            OFS_CNT_CV: rd_nxt = {16'h0000, cnt_cv_r[sel_r]};
            OFS_CNT_SV: rd_nxt = {16'h0000, cnt_sv_r[sel_r]};
            OFS_CNT_ST: begin
                rd_nxt[ST_OUT_BIT] = cnt_ct_r[sel_r];
                rd_nxt[CST_LATCH_BIT] = cnt_latch_r[sel_r];
            end
            OFS_SCANS: rd_nxt = scans_r;
            default: hit_ok = 1'b0; // unmapped reads zero, flags error
        endcase
    end

    // apb slave: one wait state, so data and ready come from flops
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            prdata <= RST_WORD;
            pslverr <= 1'b0;
            sel_r <= '0;
        end else if (ce) begin
            pready <= psel && penable && !pready;
            if (psel && penable && !pready) begin
                prdata <= pwrite ? RST_WORD : rd_nxt;
                pslverr <= !hit_ok;
            end else begin
                pslverr <= 1'b0;
            end
            if (bus_wr && paddr == OFS_SEL) begin
                sel_r <= pwdata[8:0];
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_cnt_edge;
        ce && is_cnt && instr.op == OP_CNT && instr.cond && !cnt_prev_r[k];
    endsequence

    property p_regen_scan;
        ce && scan_end && !is_out |=> phys_out == $past(out_img_r);
    endproperty
    a_regen_scan: assert property (p_regen_scan)
        else $error("regenerated outputs not written at scan end");

    property p_direct_now;
        ce && is_out && instr.op == OP_IMMEDIATE_OUTPUT_POINT
        |=> phys_out[$past(ko)] == $past(instr.cond);
    endproperty
    a_direct_now: assert property (p_direct_now)
        else $error("direct output not written at once");

    property p_cnt_rst;
        ce && is_cnt && instr.op == OP_CNT_RST
        |=> cnt_cv_r[$past(k)] == CV_ZERO && !cnt_ct_r[$past(k)];
    endproperty
    a_cnt_rst: assert property (p_cnt_rst)
        else $error("counter reset left value or contact");

    property p_cnt_stop;
        s_cnt_edge ##0 (cnt_cv_r[k] == eff_sv(instr.setv))
        |=> cnt_cv_r[$past(k)] == $past(cnt_cv_r[k]);
    endproperty
    a_cnt_stop: assert property (p_cnt_stop)
        else $error("counter moved past its set value");

    property p_cnt_inc;
        s_cnt_edge ##0 (cnt_cv_r[k] < eff_sv(instr.setv))
        |=> cnt_cv_r[$past(k)] == $past(cnt_cv_r[k]) + 16'h0001;
    endproperty
    a_cnt_inc: assert property (p_cnt_inc)
        else $error("counter did not step by one");

    property p_cnt_over;
        s_cnt_edge ##0 (cnt_cv_r[k] > eff_sv(instr.setv))
        |=> cnt_cv_r[$past(k)] == eff_sv($past(instr.setv))
            ##0 cnt_hit_r[$past(k)];
    endproperty
    a_cnt_over: assert property (p_cnt_over)
        else $error("oversized value not loaded with set value");

    property p_ct_scan;
        ce && !scan_end && !pwr_lost && !is_cnt |=> $stable(cnt_ct_r);
    endproperty
    a_ct_scan: assert property (p_ct_scan)
        else $error("counter contact changed outside scan end");

    property p_gen_clear;
        ce && is_tmr && instr.op != OP_TMR_RST && !instr.cond &&
        !instr.accum_timer_prefix
        |=> tmr_cv_r[$past(k)] == CV_ZERO && !tmr_coil_r[$past(k)];
    endproperty
    a_gen_clear: assert property (p_gen_clear)
        else $error("general timer not cleared on false condition");

    property p_acc_hold;
        ce && is_tmr && instr.op != OP_TMR_RST && !instr.cond &&
        instr.accum_timer_prefix && !scan_end && !pwr_lost && !bus_wr
        && !tmr_out_r[k]
        |=> tmr_cv_r[$past(k)] == $past(tmr_cv_r[k]);
    endproperty
    a_acc_hold: assert property (p_acc_hold)
        else $error("accumulative timer lost its value");

    property p_fine_tick;
        tick_fine |-> ##1 !tick_fine [*8];
    endproperty
    a_fine_tick: assert property (p_fine_tick)
        else $error("fine ticks too close together");

endmodule

`default_nettype wire

// ---- test/ptc_testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ptc_pkg::*;
    localparam int FC = 10; // short tick, wide enough for the spacing check
    logic core_clk, nrst, ce, scan_end, pwr_lost, psel, penable, pwrite;
    logic [7:0] paddr; // bus address
    logic [31:0] pwdata, prdata, rd; // bus data, last read word
    logic pready, pslverr, serr; // serr holds the last error flag
    logic [NUM_OUT-1:0] phys_out; // output pins
    ptc_instr_s instr; // engine instruction
    int err_total, num_checks;
    ptc_timer_counter #(.FINE_CYCLES(FC)) u_ptc_timer_counter (
        .core_clk(core_clk), .nrst(nrst), .ce(ce), .instr(instr),
        .scan_end(scan_end), .pwr_lost(pwr_lost), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .phys_out(phys_out));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // one comparison, counted; unknowns never match
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // apb transfer; the request stands until pready is seen at an edge
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
        if (n >= 20) begin
            err_total++; // a hung bus ends the run
            finish_test();
        end
    endtask
    // one executed instruction, then an idle edge
    task automatic ins(ptc_op_e op, int i, logic c, int sv, logic acc = 0);
        instr <= '{1'b1, op, 9'(i), c, acc, 16'(sv)};
        @(posedge core_clk);
        instr.valid <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic scan;
        scan_end <= 1'b1;
        @(posedge core_clk);
        scan_end <= 1'b0;
        @(posedge core_clk);
    endtask
    // one-cycle power loss pulse
    task automatic pwr;
        pwr_lost <= 1'b1;
        @(posedge core_clk);
        pwr_lost <= 1'b0;
    endtask
    // counting, saturation, scan-end contact, reset, overrange, power
    task automatic t_counter;
        apb(1, OFS_SEL, 32'h0000_0003);
        for (int i = 1; i <= 3; i++) begin
            ins(OP_CNT, 3, 0, 2);
            ins(OP_CNT, 3, 1, 2);
            apb(0, OFS_CNT_CV, 0);
            check("cnt_cv", rd, (i > 2) ? 2 : i);
            if (i == 2) begin
                apb(0, OFS_CNT_ST, 0);
                check("cnt_pre", rd[0], 0);
                scan();
                apb(0, OFS_CNT_ST, 0);
                check("cnt_ct", rd[0], 1);
            end
        end
        ins(OP_CNT_RST, 3, 1, 2);
        apb(0, OFS_CNT_CV, 0);
        check("rst_cv", rd, 0);
        apb(0, OFS_CNT_ST, 0);
        check("rst_ct", rd[0], 0);
        ins(OP_CNT, 3, 0, 0);
        ins(OP_CNT, 3, 1, 0);
        scan();
        apb(0, OFS_CNT_ST, 0);
        check("sv0_ct", rd[0], 1);
        apb(1, OFS_CNT_CV, 32'h0000_000A);
        ins(OP_CNT, 3, 0, 3);
        ins(OP_CNT, 3, 1, 3);
        apb(0, OFS_CNT_CV, 0);
        check("over_cv", rd, 3);
        pwr();
        apb(0, OFS_CNT_CV, 0);
        check("pwr_cv", rd, 0);
        // a latching counter rides through the next power loss
        apb(1, OFS_CNT_ST, 32'h0000_0002);
        ins(OP_CNT, 3, 0, 3);
        ins(OP_CNT, 3, 1, 3);
        pwr();
        apb(0, OFS_CNT_CV, 0);
        check("latch_cv", rd, 1);
        apb(0, OFS_CNT_ST, 0);
        check("latch_bit", rd[1], 1);
        $display("test counter done");
    endtask
    // fine, medium, coarse, accumulative and upper-range timers
    task automatic t_timer;
        logic [31:0] held;
        apb(1, OFS_SEL, 32'h0000_0005);
        ins(OP_FINE_TIMER_INSTR, 5, 1, 3);
        repeat (4 * FC) @(posedge core_clk);
        apb(0, OFS_TMR_CV, 0);
        check("fine_cv", rd >= 3 && rd <= 6, 1);
        apb(0, OFS_TMR_ST, 0);
        check("fine_st", rd[1:0], 2'b11);
        ins(OP_FINE_TIMER_INSTR, 5, 0, 3);
        apb(0, OFS_TMR_CV, 0);
        check("gen_cv", rd, 0);
        apb(0, OFS_TMR_ST, 0);
        check("gen_ct", rd[0], 0);
        scan();
        ins(OP_FINE_TIMER_INSTR, 5, 1, 100, 1);
        repeat (3 * FC) @(posedge core_clk);
        ins(OP_FINE_TIMER_INSTR, 5, 0, 100, 1);
        apb(0, OFS_TMR_CV, 0);
        held = rd;
        check("acc_run", held > 0, 1);
        repeat (3 * FC) @(posedge core_clk);
        apb(0, OFS_TMR_CV, 0);
        check("acc_hold", rd, held);
        scan();
        apb(1, OFS_SEL, 32'h0000_0006);
        ins(OP_ALT_TIMER_INSTR, 6, 1, 50);
        repeat (21 * FC) @(posedge core_clk);
        apb(0, OFS_TMR_CV, 0);
        check("alt_cv", rd >= 2 && rd <= 3, 1);
        // coarse unit is a hundred fine ticks
        apb(1, OFS_SEL, 32'h0000_0007);
        ins(OP_TIMER_INSTR, 7, 1, 1);
        repeat (101 * FC) @(posedge core_clk);
        apb(0, OFS_TMR_CV, 0);
        check("coarse_cv", rd >= 1 && rd <= 2, 1);
        apb(0, OFS_TMR_ST, 0);
        check("coarse_st", rd[1:0], 2'b11);
        // upper timers bank ticks and add them at scan end
        apb(1, OFS_SEL, 32'h0000_019C);
        ins(OP_FINE_TIMER_INSTR, 412, 1, 2);
        repeat (4 * FC) @(posedge core_clk);
        apb(0, OFS_TMR_CV, 0);
        check("fb_bank", rd, 0);
        scan();
        apb(0, OFS_TMR_CV, 0);
        check("fb_scan", rd >= 3 && rd <= 6, 1);
        $display("test timer done");
    endtask
    // direct outputs at once, regenerated ones at scan end; bus errors
    task automatic t_out_bus;
        apb(0, OFS_SCANS, 0);
        check("scans", rd, 5);
        ins(OP_IMMEDIATE_OUTPUT_POINT, 5, 1, 0);
        check("direct", phys_out[5], 1);
        ins(OP_OUT, 6, 1, 0);
        check("regen_pre", phys_out[6], 0);
        scan();
        check("regen", phys_out[6], 1);
        apb(0, 8'hFC, 0);
        check("unmapped_err", serr, 1);
        check("unmapped_rd", rd, 0);
        // with ce low an executed instruction leaves no trace
        ce <= 1'b0;
        ins(OP_IMMEDIATE_OUTPUT_POINT, 7, 1, 0);
        ce <= 1'b1;
        check("ce_freeze", phys_out[7], 0);
        $display("test outputs and bus done");
    endtask
    initial begin
        err_total = 0;
        num_checks = 0;
        nrst = 1'b0;
        ce = 1'b1;
        scan_end = 1'b0;
        pwr_lost = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        instr = '0;
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        apb(0, OFS_TMR_ST, 0); check("rst_word", rd, RST_WORD);
        t_counter();
        t_timer();
        t_out_bus();
        finish_test();
    end
endmodule
`default_nettype wire
